// [csr_pkg.sv]
// constants, field layout and state codes of the core system registers
// What this block does
// RL1: first pointer holds 5-bit block number
// RL2: second pointer holds twin-high block number
// RL3: twin instructions set mode bit, single clears
// RL4: low two pointer bits always read zero
// RL5: page pointer holds 6-bit page number
// RL6: up to 64 pages, present only if fitted
// RL7: interrupt entry never stacks the page pointer
// RL8: mode bit 7 places system stack
// RL9: mode bit 6 places user stack
// RL10: mode bit 5 halves oscillator clock
// RL11: mode bits 4:2 set clock prescaler
// RL12: mode bit 1 enables bus request pin
// RL13: mode bit 0 floats external bus lines
// RL14: push pre-decrements, pop post-increments pointer
// RL15: pop never writes the stack location
// RL16: interrupt pushes PC, flags, optional code segment
// RL17: calls push PC, segment calls add segment
// RL18: register-file stacks use low pointer byte only
// RL19: software keeps stacks out of system groups
// RL20: single mode rounds block down to even
// RL21: prescaler divides by field value plus one
// RL22: user pointer is high:low, carries in memory
package csr_pkg;
   localparam logic [7:0] ADDR_WP0      = 8'hE8;
   localparam logic [7:0] ADDR_WP1      = 8'hE9;
   localparam logic [7:0] ADDR_PAGE     = 8'hEA;
   localparam logic [7:0] ADDR_MODE     = 8'hEB;
   localparam logic [7:0] ADDR_USP_HIGH = 8'hEC;
   localparam logic [7:0] ADDR_USP_LOW  = 8'hED;
   // field positions
   localparam int BLOCK_LSB      = 3;
   localparam int PTR_MODE_BIT   = 2;
   localparam int PAGE_LSB       = 2;
   localparam int MODE_SYS_STK   = 7;
   localparam int MODE_USR_STK   = 6;
   localparam int MODE_HALVING   = 5;
   localparam int MODE_DIV_LSB   = 2;
   localparam int MODE_BUS_REQ   = 1;
   localparam int MODE_FLOAT     = 0;
   // reset values and page count
   localparam logic [7:0]  WP_RESET    = 8'h00;
   localparam logic [7:0]  PAGE_RESET  = 8'h00;
   localparam logic [7:0]  MODE_RESET  = 8'hE0;
   localparam logic [15:0] USP_RESET   = 16'h0000;
   localparam int          PAGE_COUNT  = 64;
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_PUSH_PC   = 4'h1,
      ST_PUSH_CS   = 4'h2,
      ST_PUSH_FL   = 4'h3,
      ST_POP_FL    = 4'h4,
      ST_POP_CS    = 4'h5,
      ST_POP_PC    = 4'h6,
      ST_PUSH_DATA = 4'h7,
      ST_POP_DATA  = 4'h8
   } csr_state_e;
endpackage

// [csr_stk_ptr.sv]
// stack pointer arithmetic for one push or pop access
`timescale 1ns/1ps
module csr_stk_ptr (
   input  wire logic [15:0] ptr,
   input  wire logic        inRegFile,
   input  wire logic        isPush,
   input  wire logic        isWord,
   output logic      [15:0] nextPtr,
   output logic      [15:0] accessAddr
);
   logic [15:0] step;
   logic [15:0] sum;

   // pre-decrement on push, post-increment on pop
   always_comb begin
      step = isWord ? 16'h0002 : 16'h0001;
      sum  = isPush ? ptr - step : ptr + step; // see RL14
      // register-file stacks wrap in the low byte only
      if (inRegFile) begin
         nextPtr = {ptr[15:8], sum[7:0]}; // see RL18
      end else begin
         nextPtr = sum; // see RL22
      end
      accessAddr = isPush ? nextPtr : ptr; // see RL14
   end
endmodule

// [csr_clk_div.sv]
// internal clock tick from oscillator halving and prescaler
`timescale 1ns/1ps
module csr_clk_div (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       clkEn,
   input  wire logic       oscHalving,
   input  wire logic [2:0] divField,
   output logic            tick
);
   logic [3:0] count;
   logic [3:0] next_count;
   logic       next_tick;
   logic [4:0] total;

   // period is (field + 1) cycles, doubled when halving is on
   always_comb begin
      total = {2'b00, divField} + 5'h01; // see RL21
      if (oscHalving) begin
         total = {total[3:0], 1'b0}; // see RL10
      end
      next_tick  = 1'b0;
      next_count = count + 4'h1;
      // a shrinking period restarts cleanly instead of running to 15
      if (count >= 4'(total - 5'h01)) begin // see RL11
         next_count = 4'h0;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= 4'h0;
         tick  <= 1'b0;
      end else if (clkEn) begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule

// [csr_core_regs.sv]
// core system registers: working pointers, page pointer, mode, stacks
`timescale 1ns/1ps
module csr_core_regs #(
   parameter bit HAS_BUS_REQUEST_PIN = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regWrEn,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regRdEn,
   output logic      [7:0]  regRdData,
   input  wire logic        setSingle,
   input  wire logic        setTwinLow,
   input  wire logic        setTwinHigh,
   input  wire logic [4:0]  setBlock,
   input  wire logic        setPage,
   input  wire logic [5:0]  setPageNum,
   input  wire logic [63:0] pagePresent,
   output logic      [5:0]  pageSel,
   output logic             pageExists,
   input  wire logic [3:0]  workIndex,
   output logic      [7:0]  workAddr,
   input  wire logic        intEntry,
   input  wire logic        intReturn,
   input  wire logic        callPlain,
   input  wire logic        callSeg,
   input  wire logic        retPlain,
   input  wire logic        retSeg,
   input  wire logic        pushCodeSeg,
   input  wire logic [15:0] progCounter,
   input  wire logic [7:0]  flags,
   input  wire logic [5:0]  codeSeg,
   input  wire logic        stackPush,
   input  wire logic        stackPop,
   input  wire logic        stackUser,
   input  wire logic        stackWord,
   input  wire logic [15:0] stackPushData,
   input  wire logic [15:0] sysStackPtr,
   output logic             sysStackPtrWr,
   output logic      [15:0] sysStackPtrNew,
   output logic             stackWrEn,
   output logic             stackRdEn,
   output logic             stackWordAcc,
   output logic             stackInRegFile,
   output logic      [15:0] stackAddr,
   output logic      [15:0] stackWrData,
   output logic             stackBusy,
   output logic             sysStackInRegFile,
   output logic             userStackInRegFile,
   output logic             oscHalving,
   output logic      [2:0]  coreClockDivider,
   output logic             internalClockTick,
   output logic             busRequestPinEn,
   output logic             busFloat
);
   // register state
   logic [7:0]  wp0, wp1, pageReg, modeReg;
   logic [7:0]  next_wp0, next_wp1, next_pageReg, next_modeReg;
   logic [7:0]  next_regRdData;
   logic [15:0] user_stack_internal, next_usp;

   // stack sequencer state
   csr_pkg::csr_state_e state, next_state;
   logic        useUserStk, withCs, dataWord;
   logic        next_useUserStk, next_withCs, next_dataWord;
   logic [15:0] spWork, dataHold, next_spWork, next_dataHold;

   // registered outputs of the stack access
   logic        next_stackWrEn, next_stackRdEn, next_stackWordAcc;
   logic        next_stackInRegFile, next_sysStackPtrWr;
   logic [15:0] next_stackAddr, next_stackWrData, next_sysStackPtrNew;
   logic        lastItem, stepPush, stepWord, stepInRf;
   logic [15:0] ptrNext, ptrAddr;

   // working register index to register file address
   function automatic logic [7:0] mapWorking(input logic [3:0] idx,
                                             input logic [7:0] p0,
                                             input logic [7:0] p1);
      if (!p0[csr_pkg::PTR_MODE_BIT]) begin
         // single mode: group starts at the even block at or below
         return {p0[7:4], idx}; // see RL20
      end else if (!idx[3]) begin
         return {p0[7:3], idx[2:0]}; // see RL1
      end else begin
         return {p1[7:3], idx[2:0]}; // see RL2
      end
   endfunction

   // pointer arithmetic shared by every stack access
   csr_stk_ptr u_stk_ptr (
      .ptr        (spWork),
      .inRegFile  (stepInRf),
      .isPush     (stepPush),
      .isWord     (stepWord),
      .nextPtr    (ptrNext),
      .accessAddr (ptrAddr)
   );

   // internal clock tick generator
   csr_clk_div u_clk_div (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .clkEn      (clkEn),
      .oscHalving (modeReg[csr_pkg::MODE_HALVING]),
      .divField   (modeReg[csr_pkg::MODE_DIV_LSB +: 3]),
      .tick       (internalClockTick)
   );

   // register next values; instructions win over a same-cycle bus write
   always_comb begin
      {next_wp0, next_wp1} = {wp0, wp1};
      {next_pageReg, next_modeReg} = {pageReg, modeReg};
      next_usp     = user_stack_internal;
      if (regWrEn) begin
         case (regAddr)
            csr_pkg::ADDR_WP0:      next_wp0 = regWrData;
            csr_pkg::ADDR_WP1:      next_wp1 = regWrData;
            csr_pkg::ADDR_PAGE:     next_pageReg = regWrData;
            csr_pkg::ADDR_MODE:     next_modeReg = regWrData; // see RL8
            csr_pkg::ADDR_USP_HIGH: next_usp[15:8] = regWrData;
            csr_pkg::ADDR_USP_LOW:  next_usp[7:0] = regWrData;
            default:                next_usp = user_stack_internal;
         endcase
      end
      if (setSingle) begin
         next_wp0[7:3] = setBlock; // see RL1
         next_wp0[csr_pkg::PTR_MODE_BIT] = 1'b0; // see RL3
         next_wp1[csr_pkg::PTR_MODE_BIT] = 1'b0;
      end else if (setTwinLow || setTwinHigh) begin
         if (setTwinLow) begin
            next_wp0[7:3] = setBlock;
         end else begin
            next_wp1[7:3] = setBlock; // see RL2
         end
         next_wp0[csr_pkg::PTR_MODE_BIT] = 1'b1; // see RL3
         next_wp1[csr_pkg::PTR_MODE_BIT] = 1'b1;
      end
      if (setPage) begin
         next_pageReg[7:csr_pkg::PAGE_LSB] = setPageNum; // see RL5
      end
      // a finishing user stack sequence owns the pointer this cycle
      if (state != csr_pkg::ST_IDLE && lastItem && useUserStk) begin
         next_usp = ptrNext; // see RL22
      end
      // reserved low bits never hold a one
      next_wp0[1:0]     = 2'b00; // see RL4
      next_wp1[1:0]     = 2'b00;
      next_pageReg[1:0] = 2'b00;
      next_regRdData = regRdData;
      if (regRdEn) begin
         case (regAddr)
            csr_pkg::ADDR_WP0:      next_regRdData = wp0;
            csr_pkg::ADDR_WP1:      next_regRdData = wp1;
            csr_pkg::ADDR_PAGE:     next_regRdData = pageReg;
            csr_pkg::ADDR_MODE:     next_regRdData = modeReg;
            csr_pkg::ADDR_USP_HIGH: next_regRdData = user_stack_internal[15:8];
            csr_pkg::ADDR_USP_LOW:  next_regRdData = user_stack_internal[7:0];
            default:                next_regRdData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         {wp0, wp1} <= {csr_pkg::WP_RESET, csr_pkg::WP_RESET};
         pageReg   <= csr_pkg::PAGE_RESET;
         modeReg   <= csr_pkg::MODE_RESET;
         user_stack_internal       <= csr_pkg::USP_RESET;
         regRdData <= 8'h00;
      end else if (clkEn) begin
         {wp0, wp1, pageReg} <= {next_wp0, next_wp1, next_pageReg};
         modeReg   <= next_modeReg;
         user_stack_internal       <= next_usp;
         regRdData <= next_regRdData;
      end
   end

   // current step of the sequencer: direction, size, placement, end
   always_comb begin
      stepPush = 1'b0;
      stepWord = 1'b0;
      lastItem = 1'b0;
      case (state)
         csr_pkg::ST_PUSH_PC: begin
            stepPush = 1'b1;
            stepWord = 1'b1;
         end
         csr_pkg::ST_PUSH_CS, csr_pkg::ST_PUSH_FL: begin
            stepPush = 1'b1;
            lastItem = 1'b1;
         end
         csr_pkg::ST_POP_PC: begin
            stepWord = 1'b1;
            lastItem = 1'b1;
         end
         csr_pkg::ST_PUSH_DATA: begin
            stepPush = 1'b1;
            stepWord = dataWord;
            lastItem = 1'b1;
         end
         csr_pkg::ST_POP_DATA: begin
            stepWord = dataWord;
            lastItem = 1'b1;
         end
         default: lastItem = 1'b0;
      endcase
      stepInRf = useUserStk ? modeReg[csr_pkg::MODE_USR_STK]
                            : modeReg[csr_pkg::MODE_SYS_STK]; // see RL9
   end

   // sequencer next state and access outputs
   always_comb begin
      next_state = state;
      {next_useUserStk, next_withCs} = {useUserStk, withCs};
      {next_dataWord, next_spWork} = {dataWord, spWork};
      {next_dataHold, next_stackWrData} = {dataHold, stackWrData};
      {next_stackAddr, next_sysStackPtrNew} = {stackAddr, sysStackPtrNew};
      {next_stackWrEn, next_stackRdEn, next_sysStackPtrWr} = 3'b000;
      {next_stackWordAcc, next_stackInRegFile} = {stepWord, stepInRf};
      case (state)
         csr_pkg::ST_IDLE: begin
            next_spWork     = sysStackPtr;
            next_useUserStk = 1'b0;
            next_withCs     = 1'b0;
            next_dataWord   = 1'b1;
            // page pointer is never part of the saved context
            if (intEntry) begin // see RL7
               next_withCs = pushCodeSeg; // see RL16
               next_state  = csr_pkg::ST_PUSH_PC;
            end else if (intReturn) begin
               next_withCs = pushCodeSeg;
               next_state  = csr_pkg::ST_POP_FL;
            end else if (callSeg || callPlain) begin
               next_withCs = callSeg; // see RL17
               next_state  = csr_pkg::ST_PUSH_PC;
            end else if (retSeg) begin
               next_withCs = 1'b1;
               next_state  = csr_pkg::ST_POP_CS;
            end else if (retPlain) begin
               next_state  = csr_pkg::ST_POP_PC;
            end else if (stackPush || stackPop) begin
               next_useUserStk = stackUser;
               next_spWork     = stackUser ? user_stack_internal : sysStackPtr;
               next_dataWord   = stackWord;
               next_dataHold   = stackPushData;
               next_state      = stackPush ? csr_pkg::ST_PUSH_DATA
                                           : csr_pkg::ST_POP_DATA;
            end
         end
         csr_pkg::ST_PUSH_PC: begin
            next_stackWrData = progCounter;
            // segment calls end after the segment, plain calls after the PC, interrupts after the flags
            next_state = withCs ? csr_pkg::ST_PUSH_CS
                       : intEntry ? csr_pkg::ST_PUSH_FL : csr_pkg::ST_IDLE;
         end
         csr_pkg::ST_PUSH_CS: begin
            next_stackWrData = {10'h000, codeSeg};
            next_state = intEntry ? csr_pkg::ST_PUSH_FL
                                  : csr_pkg::ST_IDLE;
         end
         csr_pkg::ST_PUSH_FL: begin
            next_stackWrData = {8'h00, flags};
            next_state = csr_pkg::ST_IDLE;
         end
         csr_pkg::ST_POP_FL: begin
            next_state = withCs ? csr_pkg::ST_POP_CS
                                : csr_pkg::ST_POP_PC;
         end
         csr_pkg::ST_POP_CS: next_state = csr_pkg::ST_POP_PC;
         csr_pkg::ST_POP_PC: next_state = csr_pkg::ST_IDLE;
         csr_pkg::ST_PUSH_DATA: begin
            next_stackWrData = dataHold;
            next_state = csr_pkg::ST_IDLE;
         end
         csr_pkg::ST_POP_DATA: next_state = csr_pkg::ST_IDLE;
         default: next_state = csr_pkg::ST_IDLE;
      endcase
      if (state != csr_pkg::ST_IDLE) begin
         next_spWork    = ptrNext; // see RL14
         next_stackAddr = ptrAddr;
         next_stackWrEn = stepPush;
         // pops only read; the location keeps its contents
         next_stackRdEn = !stepPush; // see RL15
         if (next_state == csr_pkg::ST_IDLE && !useUserStk) begin
            next_sysStackPtrWr  = 1'b1;
            next_sysStackPtrNew = ptrNext;
         end
      end
   end

   // the interrupt item sequence reads intEntry held by the core
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= csr_pkg::ST_IDLE;
         {useUserStk, withCs, dataWord, stackBusy} <= 4'h0;
         {spWork, dataHold, stackAddr, stackWrData} <= 64'h0;
         {stackWrEn, stackRdEn, stackWordAcc, stackInRegFile} <= 4'h0;
         {sysStackPtrWr, sysStackPtrNew} <= 17'h0;
      end else if (clkEn) begin
         state          <= next_state;
         {useUserStk, withCs} <= {next_useUserStk, next_withCs};
         {dataWord, spWork} <= {next_dataWord, next_spWork};
         dataHold       <= next_dataHold;
         {stackWrEn, stackRdEn} <= {next_stackWrEn, next_stackRdEn};
         stackWordAcc   <= next_stackWordAcc;
         stackInRegFile <= next_stackInRegFile;
         stackAddr      <= next_stackAddr;
         stackWrData    <= next_stackWrData;
         sysStackPtrWr  <= next_sysStackPtrWr;
         sysStackPtrNew <= next_sysStackPtrNew;
         stackBusy      <= (next_state != csr_pkg::ST_IDLE);
      end
   end

   // decoded mode, page and working-register outputs, all registered
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         {pageSel, pageExists, workAddr} <= 15'h0000;
         // mode outputs restart from the mode register's own reset value
         {sysStackInRegFile, userStackInRegFile, oscHalving, coreClockDivider,
          busRequestPinEn, busFloat} <= csr_pkg::MODE_RESET;
      end else if (clkEn) begin
         pageSel    <= pageReg[7:csr_pkg::PAGE_LSB]; // see RL5
         pageExists <= pagePresent[pageReg[7:csr_pkg::PAGE_LSB]]; // see RL6
         workAddr   <= mapWorking(workIndex, wp0, wp1);
         sysStackInRegFile  <= modeReg[csr_pkg::MODE_SYS_STK]; // see RL8
         userStackInRegFile <= modeReg[csr_pkg::MODE_USR_STK]; // see RL9
         oscHalving         <= modeReg[csr_pkg::MODE_HALVING]; // see RL10
         coreClockDivider   <= modeReg[csr_pkg::MODE_DIV_LSB +: 3];
         // without the pin fitted the enable bit is simply ignored
         busRequestPinEn <= modeReg[csr_pkg::MODE_BUS_REQ]
                            & HAS_BUS_REQUEST_PIN; // see RL12
         // pads float only bus-configured lines while this is high
         busFloat <= modeReg[csr_pkg::MODE_FLOAT]; // see RL13
      end
   end
endmodule

// [csr_core_regs_sva.sv]
// port checker for the core system registers
`timescale 1ns/1ps
module csr_core_regs_sva (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  regAddr,
   input wire logic        regWrEn,
   input wire logic [7:0]  regWrData,
   input wire logic        regRdEn,
   input wire logic [7:0]  regRdData,
   input wire logic        setPage,
   input wire logic [5:0]  setPageNum,
   input wire logic [5:0]  pageSel,
   input wire logic        callPlain,
   input wire logic        callSeg,
   input wire logic        intEntry,
   input wire logic        intReturn,
   input wire logic        pushCodeSeg,
   input wire logic        stackBusy,
   input wire logic        stackWrEn,
   input wire logic        stackRdEn,
   input wire logic        stackWordAcc,
   input wire logic        stackInRegFile,
   input wire logic [15:0] stackAddr,
   input wire logic        sysStackPtrWr,
   input wire logic [15:0] sysStackPtrNew,
   input wire logic        sysStackInRegFile,
   input wire logic        busFloat
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   AST_LOW_BITS: assert property (
      regRdEn && regAddr inside {8'hE8, 8'hE9, 8'hEA}
      |=> regRdData[1:0] == 2'b00) else $error("pointer low bits set");
   AST_PAGE_SEL: assert property (
      setPage |-> ##2 pageSel == $past(setPageNum, 2))
      else $error("page select wrong");
   AST_SYS_STACK: assert property (
      regWrEn && regAddr == 8'hEB
      |-> ##2 sysStackInRegFile == $past(regWrData[7], 2))
      else $error("system stack place wrong");
   AST_FLOAT: assert property (
      regWrEn && regAddr == 8'hEB |-> ##2 busFloat == $past(regWrData[0], 2))
      else $error("bus float wrong");
   // register-file stacks keep the high byte, so only the low byte is seen
   AST_PUSH_PTR: assert property (
      stackWrEn && sysStackPtrWr |-> (stackInRegFile ?
      sysStackPtrNew[7:0] == stackAddr[7:0] : sysStackPtrNew == stackAddr))
      else $error("push pointer not predecremented");
   AST_POP_PTR: assert property (
      stackRdEn && sysStackPtrWr && !stackInRegFile |->
      sysStackPtrNew == stackAddr + (stackWordAcc ? 16'h0002 : 16'h0001))
      else $error("pop pointer not postincremented");
   AST_POP_NO_WRITE: assert property (
      stackRdEn |-> !stackWrEn) else $error("pop wrote the stack");
   AST_PLAIN_CALL: assert property (
      callPlain && !stackBusy && !intEntry && !intReturn && !callSeg
      |-> ##2 stackWrEn && stackWordAcc ##1 !stackWrEn)
      else $error("plain call push wrong");
   AST_INT_ENTRY: assert property (
      $rose(intEntry) && !stackBusy |-> ##2 stackWrEn && stackWordAcc
      ##1 stackWrEn && !stackWordAcc ##1 stackWrEn == pushCodeSeg
      ##1 !stackWrEn) else $error("interrupt push count wrong");
endmodule

bind csr_core_regs csr_core_regs_sva CHK (.*);

// [csr_core_regs_bench.sv]
// self-checking bench of the core system registers
`timescale 1ns/1ps
module csr_core_regs_bench;
   logic        clk_sys, rst, clkEn, regWrEn, regRdEn, setSingle, setTwinLow;
   logic        setTwinHigh, setPage, intEntry, intReturn, callPlain, callSeg;
   logic        retPlain, retSeg, pushCodeSeg, stackPush, stackPop, stackUser;
   logic        stackWord, sysStackPtrWr, stackWrEn, stackRdEn, stackWordAcc;
   logic        stackInRegFile, stackBusy, sysStackInRegFile, busFloat;
   logic        userStackInRegFile, oscHalving, internalClockTick, pageExists;
   logic        busRequestPinEn, rfv;
   logic        rdFlag = 1'b0;
   logic [2:0]  coreClockDivider;
   logic [3:0]  workIndex;
   logic [4:0]  setBlock, b0, b1;
   logic [5:0]  setPageNum, pageSel, codeSeg, p;
   logic [7:0]  regAddr, regWrData, regRdData, flags, workAddr, v, w1, mode;
   logic [15:0] progCounter, stackPushData, sysStackPtr, sysStackPtrNew, sv;
   logic [15:0] stackAddr, stackWrData;
   logic [63:0] pagePresent;
   logic [7:0]  rq[$];
   logic [31:0] wq[$];
   int          mismatches, total_checks, cycles, seed, i, j, k;
   wire  [7:0]  modeOut = {sysStackInRegFile, userStackInRegFile, oscHalving,
                           coreClockDivider, busRequestPinEn, busFloat};

   csr_core_regs DUT (.*);

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task final_report;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task cmp8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task cmp32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      if (a == 8'hEB) mode = d;
      @(posedge clk_sys);
      regWrEn <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      regAddr <= a;
      regRdEn <= 1'b1;
      rq.push_back(e);
      @(posedge clk_sys);
      regRdEn <= 1'b0;
   endtask

   task setp(input int op, input logic [4:0] b);
      @(posedge clk_sys);
      setBlock <= b;
      {setSingle, setTwinLow, setTwinHigh} <= 3'b001 << op;
      @(posedge clk_sys);
      {setSingle, setTwinLow, setTwinHigh} <= 3'b000;
   endtask

   task work(input logic [3:0] idx, input logic [7:0] e);
      @(posedge clk_sys);
      workIndex <= idx;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp8(workAddr, e);
   endtask

   // register-file stacks wrap in the low byte only
   task note(input logic [7:0] d, input logic [15:0] x);
      wq.push_back({rfv ? {sv[15:8], sv[7:0] + d} : sv + {{8{d[7]}}, d}, x});
   endtask

   // ops: int, iret, call, calls, ret, rets, user push, user pop
   task stk(input int op, input logic [15:0] s);
      logic [15:0] pc;
      logic [7:0]  fl;
      logic [5:0]  cs;
      pc = $random(seed);
      fl = $random(seed);
      cs = $random(seed);
      sv = s;
      rfv = op > 5 ? mode[6] : mode[7];
      @(posedge clk_sys);
      {sysStackPtr, progCounter, flags, codeSeg} <= {s, pc, fl, cs};
      {stackPushData, stackUser, stackWord} <= {pc, op > 5, 1'b1};
      case (op)
         0, 2, 3, 6: note(8'hFE, pc);
         default: note(8'h00, 16'h0000);
      endcase
      if (op == 3 || (op == 0 && pushCodeSeg)) note(8'hFD, {10'h000, cs});
      if (op == 0) note(pushCodeSeg ? 8'hFC : 8'hFD, {8'h00, fl});
      if (op == 5 || (op == 1 && pushCodeSeg)) note(8'h01, 16'h0000);
      if (op == 1) note(pushCodeSeg ? 8'h02 : 8'h01, 16'h0000);
      @(posedge clk_sys);
      {intEntry, intReturn, callPlain, callSeg, retPlain, retSeg, stackPush,
       stackPop} <= 8'h80 >> op;
      // entry level drops before idle, else a second entry is taken
      repeat (op == 0 ? (pushCodeSeg ? 4 : 3) : 1) @(posedge clk_sys);
      {intEntry, intReturn, callPlain, callSeg, retPlain, retSeg, stackPush,
       stackPop} <= 8'h00;
      k = 0;
      do @(negedge clk_sys); while (stackBusy !== 1'b0 && ++k < 20);
      if (k == 20) mismatches++;
      repeat (2) @(posedge clk_sys);
   endtask

   always @(posedge clk_sys) rdFlag <= regRdEn;

   // results are matched against the oldest note as they appear
   always @(negedge clk_sys) begin
      if (rdFlag) cmp8(regRdData, rq.pop_front());
      if (stackWrEn || stackRdEn)
         cmp32({stackAddr, stackRdEn ? 16'h0000 : stackWrData},
               wq.pop_front());
   end

   // hang guard, well above the run's length
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 3000) begin
         mismatches++;
         final_report;
      end
   end

   initial begin
      seed = 32'h38DE;
      {rst, clkEn, mode} = {2'b11, 8'hE0};
      {regAddr, regWrEn, regWrData, regRdEn, setSingle, setTwinLow} = '0;
      {setTwinHigh, setBlock, setPage, setPageNum, workIndex, intEntry} = '0;
      {intReturn, callPlain, callSeg, retPlain, retSeg, pushCodeSeg} = '0;
      {progCounter, flags, codeSeg, stackPush, stackPop, stackUser} = '0;
      {stackWord, stackPushData, sysStackPtr} = '0;
      pagePresent = {$random(seed), $random(seed)};
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      for (i = 0; i < 7; i++)
         rd(8'hE8 + i[7:0], i == 3 ? 8'hE0 : 8'h00);
      cmp8(modeOut, 8'hE0);
      $display("test reset done");
      repeat (4) begin
         v = $random(seed);
         wr(8'hEB, v);
         // skip two ticks so the old divider count has flushed
         repeat (2) begin
            k = 0;
            do begin
               @(negedge clk_sys);
               k++;
            end while (internalClockTick !== 1'b1 && k < 40);
         end
         cmp8(k[7:0], (v[4:2] + 8'h01) << v[5]);
         cmp8(modeOut, v);
         rd(8'hEB, v);
      end
      $display("test mode done");
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         wr(8'hE8 + i[7:0], v);
         rd(8'hE8 + i[7:0], v & 8'hFC);
         if (i == 1) w1 = v & 8'hFC;
      end
      {b0, b1} = $random(seed);
      setp(1, b0);
      rd(8'hE8, {b0, 3'b100});
      rd(8'hE9, w1 | 8'h04);
      setp(0, b1);
      rd(8'hE9, {b1, 3'b100});
      work(4'h3, {b0, 3'h3});
      work(4'hC, {b1, 3'h4});
      setp(2, b0 | 5'h01);
      rd(8'hE8, {b0 | 5'h01, 3'b000});
      rd(8'hE9, {b1, 3'b000});
      work(4'hD, {b0[4:1], 4'hD});
      $display("test pointers done");
      p = $random(seed);
      @(posedge clk_sys);
      {setPage, setPageNum} <= {1'b1, p};
      @(posedge clk_sys);
      setPage <= 1'b0;
      rd(8'hEA, {p, 2'b00});
      cmp8({2'b00, pageSel}, {2'b00, p});
      cmp8({7'h00, pageExists}, {7'h00, pagePresent[p]});
      $display("test page done");
      wr(8'hEB, 8'h00);
      for (j = 0; j < 2; j++) begin
         pushCodeSeg <= j[0];
         for (i = 0; i < 6; i++) stk(i, $random(seed));
      end
      wr(8'hEB, 8'hC0);
      stk(2, 16'h1201);
      wr(8'hEB, 8'h00);
      wr(8'hEC, 8'h01);
      wr(8'hED, 8'h00);
      stk(6, 16'h0100);
      rd(8'hEC, 8'h00);
      rd(8'hED, 8'hFE);
      stk(7, 16'h00FE);
      rd(8'hEC, 8'h01);
      cmp8({2'b00, pageSel}, {2'b00, p});
      $display("test stacks done");
      repeat (2) @(posedge clk_sys);
      final_report;
   end
endmodule
